// *** hw/ldsp_pkg.sv ***
/*
 * Types shared by the loop DAC serial port design.
 * Assumes the register header sits in the same folder.
 */
`include "ldsp_regs.svh"

package ldsp_pkg;
    // Static select pins travelling together
    typedef struct packed {
        logic       alarm_up;
        logic       sense_int;
        logic [1:0] loop_span;
    } ldsp_sel_s;

    // Fault sources feeding the alert output
    typedef struct packed {
        logic link_loss;
        logic packet_error_check;
        logic loop_range;
        logic loop_voltage;
        logic overtemp;
    } ldsp_fault_s;
endpackage : ldsp_pkg

// *** hw/ldsp_port.sv ***
/*
 * Loop DAC serial port: serial shift in/out, frame latch, load strobe,
 * fault alert, static selects, Avalon-MM register slave with interrupt.
 * Assumes serial pins asynchronous to clk, serial clock <= clk/2.
 */
`timescale 1ns/1ns
`include "ldsp_regs.svh"

module ldsp_port
    import ldsp_pkg::*;
#(
    parameter int FRAME_W = `LDSP_FRAME_BITS
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        shift_clk,
    input  wire logic        frame_sel_n,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             serial_out_oe,
    input  wire logic        load_strobe_n,
    output logic             fault_alert,
    input  wire logic        alarm_dir,
    input  wire logic        sense_resistor_select,
    input  wire logic        loop_span_sel0,
    input  wire logic        loop_span_sel1,
    input  wire logic [7:0]  loop_voltage_monitor,
    output logic             alarm_up,
    output logic             sense_internal,
    output logic [1:0]       loop_span,
    output logic             irq
);
    localparam int CNT_W = $clog2(FRAME_W + 1);
    // Fastest serial half period in clk cycles, must stay at least 1
    localparam int HALF_CYC = `LDSP_CLK_MHZ / (2 * `LDSP_SCLK_MAX_MHZ);

    // Synchronised pins
    logic [3:0]  pin_s;
    logic [7:0]  vmon_s;
    logic [3:0]  sel_s;
    ldsp_sel_s   sel;
    logic        sclk_s, fsel_n_s, serial_in_s, load_strobe_n_n_s;
    logic        sclk_d_r, fsel_d_r, load_strobe_n_d_r;
    logic        sclk_rise, sclk_fall, fsel_rise, fsel_fall, load_strobe_n_fall;

    // Reset to idle pin levels so no false edge follows reset
    ldsp_sync #(.W(4), .RST_VAL(4'hD)) u_sync_link (
        .clk (clk),
        .rst (rst),
        .d   ({shift_clk, frame_sel_n, serial_in, load_strobe_n}),
        .q   (pin_s)
    );
    ldsp_sync #(.W(12)) u_sync_static (
        .clk (clk),
        .rst (rst),
        .d   ({loop_voltage_monitor, alarm_dir, sense_resistor_select,
               loop_span_sel1, loop_span_sel0}),
        .q   ({vmon_s, sel_s})
    );

    assign sclk_s   = pin_s[3];
    assign fsel_n_s = pin_s[2];
    assign serial_in_s   = pin_s[1];
    assign load_strobe_n_n_s = pin_s[0];
    assign sel      = ldsp_sel_s'(sel_s);

    // Edge detection on synchronised levels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_d_r <= 1'b1;
            fsel_d_r <= 1'b1;
            load_strobe_n_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            fsel_d_r <= fsel_n_s;
            load_strobe_n_d_r <= load_strobe_n_n_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign sclk_fall = ~sclk_s & sclk_d_r;
    assign fsel_rise = fsel_n_s & ~fsel_d_r;
    assign fsel_fall = ~fsel_n_s & fsel_d_r;
    assign load_strobe_n_fall = ~load_strobe_n_n_s & load_strobe_n_d_r;

    // Shift registers and bit counter
    logic [FRAME_W-1:0] shift_in_r, shift_out_r;
    logic [FRAME_W-1:0] input_reg_r, dac_reg_r;
    logic [CNT_W-1:0]   bit_cnt_r;
    logic               in_frame;
    logic [7:0]         vmon_r;
    ldsp_fault_s        fault_src;
    logic [31:0]        ctrl_r;

    assign in_frame = ~fsel_n_s;

    // Input shift, falling edges within a frame only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_in_r <= `LDSP_FRAME_RST;
            bit_cnt_r  <= '0;
        end else if (fsel_fall) begin
            bit_cnt_r  <= '0;
        end else if (in_frame && sclk_fall) begin
            shift_in_r <= {shift_in_r[FRAME_W-2:0], serial_in_s};
            if (bit_cnt_r != CNT_W'(FRAME_W))
                bit_cnt_r <= bit_cnt_r + 1'b1;
        end
    end

    // Output shift, readback loaded at frame start, moves on rising edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_out_r   <= `LDSP_FRAME_RST;
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
        end else if (fsel_fall) begin
            // MSB goes out now, so the first rise must show the next bit
            shift_out_r   <= {dac_reg_r[FRAME_W-2:8], vmon_r, 1'b0};
            serial_out_oe <= 1'b1;
            serial_out    <= dac_reg_r[FRAME_W-1];
        end else if (fsel_rise) begin
            serial_out_oe <= 1'b0;
        end else if (in_frame && sclk_rise) begin
            serial_out  <= shift_out_r[FRAME_W-1];
            shift_out_r <= {shift_out_r[FRAME_W-2:0], 1'b0};
        end
    end

    // Frame latch into input register, DAC update per load strobe
    logic frame_done, dac_pend_r, dac_upd;
    assign frame_done = fsel_rise && bit_cnt_r != '0;
    assign dac_upd = (frame_done && !load_strobe_n_n_s)
                   || (load_strobe_n_fall && dac_pend_r);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            input_reg_r <= `LDSP_FRAME_RST;
            dac_pend_r  <= 1'b0;
        end else begin
            if (frame_done)
                input_reg_r <= shift_in_r;
            if (frame_done && load_strobe_n_n_s)
                dac_pend_r <= 1'b1;
            else if (dac_upd)
                dac_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            dac_reg_r <= `LDSP_FRAME_RST;
        else if (dac_upd)
            dac_reg_r <= frame_done ? shift_in_r : input_reg_r;
    end

    // Static selects and loop voltage value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alarm_up       <= 1'b0;
            sense_internal <= 1'b0;
            loop_span      <= 2'h0;
            vmon_r         <= 8'h00;
        end else begin
            alarm_up       <= sel.alarm_up;
            sense_internal <= sel.sense_int;
            loop_span      <= sel.loop_span;
            vmon_r         <= vmon_s;
        end
    end

    // Fault sources are software-driven control bits
    assign fault_src = ldsp_fault_s'(ctrl_r[`LDSP_CTRL_FAULTS]);

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            fault_alert <= 1'b0;
        else
            fault_alert <= |fault_src;
    end

    // Register slave
    logic [`LDSP_ST_W-1:0] status_r, mask_r, st_set;
    logic                  wr_acc, rd_acc;

    assign st_set = {fault_alert == 1'b0 && (|fault_src),
                     dac_upd, frame_done};
    assign wr_acc = avs_write && !avs_waitrequest; // Lands as access ends
    assign rd_acc = avs_read && avs_waitrequest;

    // One wait cycle then the access completes
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            avs_waitrequest <= 1'b1;
        else if ((avs_read || avs_write) && avs_waitrequest)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= `LDSP_CTRL_RST;
            mask_r <= `LDSP_MASK_RST;
        end else if (wr_acc) begin
            if (avs_address == `LDSP_IDX_CTRL)
                ctrl_r <= {27'h0, avs_writedata[`LDSP_CTRL_FAULTS]};
            if (avs_address == `LDSP_IDX_MASK)
                mask_r <= avs_writedata[`LDSP_ST_W-1:0];
        end
    end

    // Sticky status, set wins over write-one-to-clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            status_r <= '0;
        else if (wr_acc && avs_address == `LDSP_IDX_STATUS)
            status_r <= (status_r & ~avs_writedata[`LDSP_ST_W-1:0]) | st_set;
        else
            status_r <= status_r | st_set;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(status_r & mask_r);
    end

    // Read data, unmapped addresses read zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            avs_readdata <= 32'h0000_0000;
        else if (rd_acc) begin
            case (avs_address)
                `LDSP_IDX_CTRL:   avs_readdata <= ctrl_r;
                `LDSP_IDX_STATUS: avs_readdata <= {29'h0, status_r};
                `LDSP_IDX_MASK:   avs_readdata <= {29'h0, mask_r};
                `LDSP_IDX_INPUT:  avs_readdata <= 32'(input_reg_r);
                `LDSP_IDX_DAC:    avs_readdata <= 32'(dac_reg_r);
                `LDSP_IDX_FAULT:  avs_readdata <= {24'h0, vmon_r};
                `LDSP_IDX_PINS:   avs_readdata <= {27'h0, dac_pend_r,
                                                   alarm_up, sense_internal,
                                                   loop_span};
                default:          avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Assertions
    initial assert (HALF_CYC >= 1)
        else $error("serial clock limit too fast for clk");

    sequence s_frame_end;
        fsel_rise && bit_cnt_r != '0;
    endsequence

    a_frame_latch: assert property (@(posedge clk) disable iff (rst)
        s_frame_end |=> input_reg_r == $past(shift_in_r))
        else $error("frame not latched on select rise");
    a_dac_direct: assert property (@(posedge clk) disable iff (rst)
        s_frame_end ##0 !load_strobe_n_n_s |=> dac_reg_r == $past(shift_in_r))
        else $error("dac not updated at frame end");
    a_dac_defer: assert property (@(posedge clk) disable iff (rst)
        s_frame_end ##0 load_strobe_n_n_s |=> dac_pend_r && $stable(dac_reg_r))
        else $error("dac updated while load strobe high");
    a_shift_in_hold: assert property (@(posedge clk) disable iff (rst)
        fsel_n_s |=> $stable(shift_in_r))
        else $error("shift register moved outside frame");
    a_shift_sample: assert property (@(posedge clk) disable iff (rst)
        in_frame && sclk_fall && !fsel_fall |=> shift_in_r[0] == $past(serial_in_s))
        else $error("serial input not sampled");
    a_out_rise_only: assert property (@(posedge clk) disable iff (rst)
        in_frame && !sclk_rise && !fsel_fall |=> $stable(serial_out))
        else $error("serial output changed off rising edge");
    a_fault_alert: assert property (@(posedge clk) disable iff (rst)
        (|fault_src) [*2] |-> fault_alert)
        else $error("fault alert not raised");
    a_vmon_read: assert property (@(posedge clk) disable iff (rst)
        rd_acc && avs_address == `LDSP_IDX_FAULT
        |=> avs_readdata[7:0] == $past(vmon_r))
        else $error("loop voltage readback wrong");
    a_span_follow: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> loop_span == $past(sel.loop_span))
        else $error("span select not followed");
endmodule : ldsp_port

// *** hw/ldsp_regs.svh ***
/*
 * Constants of the loop DAC serial port: offsets, fields, resets, timing.
 * Assumes inclusion by bare name; the guard makes repeats harmless.
 */
`ifndef LDSP_REGS_SVH
`define LDSP_REGS_SVH

// Register word indices, byte address is four times the index
`define LDSP_IDX_CTRL      3'h0
`define LDSP_IDX_STATUS    3'h1
`define LDSP_IDX_MASK      3'h2
`define LDSP_IDX_INPUT     3'h3
`define LDSP_IDX_DAC       3'h4
`define LDSP_IDX_FAULT     3'h5
`define LDSP_IDX_PINS      3'h6

// Status and mask bit positions
`define LDSP_ST_FRAME      0
`define LDSP_ST_DACUPD     1
`define LDSP_ST_FAULT      2
`define LDSP_ST_W          3

// Control register fields
`define LDSP_CTRL_FAULTS   4:0
`define LDSP_CTRL_FAULT_W  5

// Reset values
`define LDSP_CTRL_RST      32'h0000_0000
`define LDSP_MASK_RST      3'h0
`define LDSP_FRAME_RST     24'h00_0000

// Frame length and serial clock limit
`define LDSP_FRAME_BITS    24
`define LDSP_SCLK_MAX_MHZ  30
`define LDSP_CLK_MHZ       100

`endif

// *** hw/ldsp_sync.sv ***
/*
 * Two flip-flop synchroniser for a vector of pin levels.
 * Assumes inputs arrive asynchronously to clk.
 */
`timescale 1ns/1ns

module ldsp_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0 // Idle level of each pin
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // First stage read only by the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : ldsp_sync

// *** test/ldsp_host.sv ***
/*
 * Host serial master model: frames, shift clock, load strobe.
 * Assumes the bench calls its tasks; link timing is free of clk.
 */
`timescale 1ns/1ns

module ldsp_host (
    output logic      shift_clk,
    output logic      frame_sel_n,
    output logic      serial_in,
    output logic      load_strobe_n,
    input  wire logic serial_out
);
    // Idle: clock parked high, no frame, strobe high
    initial begin
        shift_clk     = 1'b1;
        frame_sel_n   = 1'b1;
        serial_in     = 1'b0;
        load_strobe_n = 1'b1;
    end

    // One 24-bit frame MSB first, 125 ns period, readout at falls
    task automatic xfer(input logic [23:0] w, output logic [23:0] rd);
        frame_sel_n <= 1'b0;
        #100;
        for (int i = 23; i >= 0; i--) begin
            serial_in <= w[i];
            #62 shift_clk <= 1'b0;
            rd[i] = serial_out;
            #63 shift_clk <= 1'b1;
        end
        #100 frame_sel_n <= 1'b1;
        serial_in <= ~serial_in; // Released line shows no stale bit
    endtask : xfer

    // Stray shift clocks with no frame open
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            serial_in <= ~serial_in;
            #62 shift_clk <= 1'b0;
            #63 shift_clk <= 1'b1;
        end
    endtask : stray

    // Load strobe level
    task automatic set_load(input logic v);
        load_strobe_n <= v;
    endtask : set_load
endmodule : ldsp_host

// *** test/testbench.sv ***
/*
 * Self-checking bench for the loop DAC serial port.
 * Assumes the design package and modules are compiled first.
 */
`timescale 1ns/1ns

module testbench
    import ldsp_pkg::*;
;
    logic        clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [2:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        shift_clk, frame_sel_n, serial_in, serial_out, oe, sdo_line;
    logic        load_strobe_n, fault_alert, irq, alarm_up, sense_int;
    logic        alarm_dir, sense_sel, span0, span1;
    logic [1:0]  loop_span;
    logic [7:0]  vmon;
    logic [23:0] rd;
    int          error_cnt, num_checks;

    // Undriven output line shows the inverse of the stale bit
    assign sdo_line = oe ? serial_out : ~serial_out;

    ldsp_port ldsp_port_inst (.clk(clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .shift_clk(shift_clk), .frame_sel_n(frame_sel_n),
        .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(oe), .load_strobe_n(load_strobe_n),
        .fault_alert(fault_alert), .alarm_dir(alarm_dir),
        .sense_resistor_select(sense_sel), .loop_span_sel0(span0),
        .loop_span_sel1(span1), .loop_voltage_monitor(vmon),
        .alarm_up(alarm_up), .sense_internal(sense_int),
        .loop_span(loop_span), .irq(irq));

    ldsp_host ldsp_host_inst (.shift_clk(shift_clk),
        .frame_sel_n(frame_sel_n), .serial_in(serial_in),
        .load_strobe_n(load_strobe_n), .serial_out(sdo_line));

    // 100 MHz system clock
    always #5 clk = ~clk;

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("Checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [2:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 50) begin
                error_cnt++;
                tally_and_finish();
            end
            @(posedge clk);
        end
        r = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    // Read a word and compare it
    task automatic rchk(input logic [2:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rchk

    // Poll status until a bit is set
    task automatic wait_st(input int b);
        for (int i = 0; i < 30; i++) begin
            bus(1'b0, 3'h1, 32'h0, q);
            if (q[b] === 1'b1)
                return;
        end
        error_cnt++;
        tally_and_finish();
    endtask : wait_st

    // Static pins and their copies
    task automatic pin_case(input logic a, input logic s,
                            input logic [1:0] sp);
        alarm_dir <= a;
        sense_sel <= s;
        {span1, span0} <= sp;
        repeat (6) @(posedge clk);
        chk({31'h0, alarm_up}, {31'h0, a});
        chk({31'h0, sense_int}, {31'h0, s});
        chk({30'h0, loop_span}, {30'h0, sp});
        rchk(3'h6, {27'h0, 1'b0, a, s, sp});
    endtask : pin_case

    // Main sequence
    initial begin
        {clk, avs_read, avs_write, alarm_dir, sense_sel} = 5'h00;
        {span0, span1} = 2'h0;
        {error_cnt, num_checks} = 0;
        avs_address   = 3'h0;
        avs_writedata = 32'h0;
        vmon          = 8'h00;
        rst           = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 8; i++)
            rchk(i[2:0], 32'h0);
        vmon <= 8'h9C;
        pin_case(1'b1, 1'b0, 2'h1);
        pin_case(1'b0, 1'b1, 2'h2);
        rchk(3'h5, 32'h9C);
        // Strobe low: frame end updates both registers
        ldsp_host_inst.set_load(1'b0);
        ldsp_host_inst.xfer(24'hA5C35A, rd);
        wait_st(0);
        chk({8'h0, rd}, 32'h00009C);
        rchk(3'h3, 32'hA5C35A);
        rchk(3'h4, 32'hA5C35A);
        rchk(3'h1, 32'h3);
        bus(1'b1, 3'h1, 32'h3, q);
        rchk(3'h1, 32'h0);
        // Strobe high: DAC waits for the strobe fall
        ldsp_host_inst.set_load(1'b1);
        repeat (5) @(posedge clk);
        ldsp_host_inst.xfer(24'h3C96E1, rd);
        wait_st(0);
        chk({8'h0, rd}, 32'hA5C39C);
        rchk(3'h3, 32'h3C96E1);
        rchk(3'h4, 32'hA5C35A);
        rchk(3'h6, 32'h16);
        ldsp_host_inst.set_load(1'b0);
        repeat (8) @(posedge clk);
        rchk(3'h4, 32'h3C96E1);
        // Shift clocks outside a frame change nothing
        bus(1'b1, 3'h1, 32'h7, q);
        ldsp_host_inst.stray(6);
        repeat (8) @(posedge clk);
        chk({31'h0, oe}, 32'h0);
        rchk(3'h3, 32'h3C96E1);
        rchk(3'h1, 32'h0);
        // Each fault source raises the alert
        for (int b = 0; b < 5; b++) begin
            bus(1'b1, 3'h0, 32'h1 << b, q);
            repeat (3) @(posedge clk);
            chk({31'h0, fault_alert}, 32'h1);
            bus(1'b1, 3'h0, 32'h0, q);
            repeat (3) @(posedge clk);
            chk({31'h0, fault_alert}, 32'h0);
        end
        // Interrupt raised by mask, dropped by clearing status
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 3'h2, 32'h4, q);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        rchk(3'h2, 32'h4);
        bus(1'b1, 3'h1, 32'h4, q);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rchk(3'h1, 32'h0);
        tally_and_finish();
    end
endmodule : testbench
